//--- srac_map.vh
`ifndef SRAC_MAP_VH
`define SRAC_MAP_VH

// =============================================
// register addresses in the global page
`define SRAC_ADDR_DATA 8'hF0
`define SRAC_ADDR_STATUS 8'hFE
`define SRAC_ADDR_PAGE 8'hFF

// =============================================
// command byte fields
`define SRAC_CMD_RW 0
`define SRAC_CMD_TGT_LO 1
`define SRAC_CMD_TGT_HI 3
`define SRAC_CMD_MODE 4
`define SRAC_CMD_TOP_LO 5
`define SRAC_CMD_TOP_HI 7
`define SRAC_NORMAL_PATTERN 3'h3
`define SRAC_TARGET_ID 3'h0

// =============================================
// status byte fields
`define SRAC_ST_DONE 7
`define SRAC_ST_READY 5
`define SRAC_ST_MDIO 2
`define SRAC_FAST_READY 0

// =============================================
// reset values and sizes
`define SRAC_PAGE_RST 8'h00
`define SRAC_BYTE_ZERO 8'h00
`define SRAC_BITS_PER_BYTE 3'h7
`define SRAC_LINK_IDLE 3'h7

`endif

//--- srac_sync.v
`timescale 1ns/1ps
// =============================================
// two flip-flop synchroniser, one per bit
module srac_sync #(
   parameter W = 3,
   parameter [W-1:0] RST = {W{1'b1}}
) (
   input wire clk_i,
   input wire arst_n_i,
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg meta;
         reg stable;
         always @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               meta <= RST[g];
               stable <= RST[g];
            end else begin
               meta <= d_i[g];
               stable <= meta;
            end
         end
         assign q_o[g] = stable;
      end
   endgenerate
endmodule // srac_sync

//--- srac_buf2.v
`timescale 1ns/1ps
// =============================================
// two-entry buffer: output stage plus skid stage,
// both registered so the drain side sees flops only
module srac_buf2 #(
   parameter W = 24
) (
   input wire clk_i,
   input wire arst_n_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   output reg out_valid_o,
   input wire out_ready_i,
   output reg [W-1:0] out_data_o
);
   reg skid_valid;
   reg [W-1:0] skid_data;
   wire take;
   wire give;

   assign in_ready_o = ~skid_valid;
   assign take = in_valid_i & ~skid_valid;
   assign give = out_valid_o & out_ready_i;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= {W{1'b0}};
         skid_valid <= 1'b0;
         skid_data <= {W{1'b0}};
      end else begin
         if (!out_valid_o || give) begin
            // refill the output stage, oldest word first
            if (skid_valid) begin
               out_valid_o <= 1'b1;
               out_data_o <= skid_data;
               skid_valid <= take;
               skid_data <= in_data_i;
            end else begin
               out_valid_o <= take;
               out_data_o <= in_data_i;
            end
         end else if (take) begin
            skid_valid <= 1'b1;
            skid_data <= in_data_i;
         end
      end
   end
endmodule // srac_buf2

//--- srac_top.v
// Function
// (RULE1) reads return status and data on serial output
// (RULE2) command byte, address byte, then data bytes
// (RULE3) host never mixes normal and fast access
// (RULE4) bit 4 zero means normal, top bits 011
// (RULE5) fast read start offset from bits 7:5
// (RULE6) target field bits 3:1 must be zero
// (RULE7) access only while select is low
// (RULE8) bit 0 chooses read or write
// (RULE9) address increments after each data byte
// (RULE10) one transaction per register
// (RULE11) select stays low for whole transaction
// (RULE12) transceiver poll status visible over serial port
// (RULE13) page register at FFh selects page
// (RULE14) data register at F0h moves register content
// (RULE15) status: done bit7, ready bit5, mdio bit2
// (RULE16) normal read, fast read, normal write only
// (RULE17) host polls done flag before access
// (RULE18) normal read is five ordered transactions
// (RULE19) host may skip unchanged page write
// (RULE20) address read copies register, eight dummy clocks
// (RULE21) ready flag set when data register loaded
// (RULE22) data register sent low byte first, msb first
// (RULE23) select changes only while clock high
// (RULE24) clock idles high, launch fall, capture rise
// (RULE25) select low across multi-byte transfers
// (RULE26) at least 200 ns between selects
// (RULE27) wrong target ignored, output left undriven
`timescale 1ns/1ps
`include "srac_map.vh"

module srac_top #(
   parameter DATA_W = 64,
   parameter IDX_W = 3
) (
   input wire clk_i,
   input wire arst_n_i,
   input wire ss_n_i,
   input wire sck_i,
   input wire mosi_i,
   output reg miso_o,
   output reg miso_oe_o,
   output reg rd_req_o,
   output reg [7:0] rd_page_o,
   output reg [7:0] rd_addr_o,
   input wire rd_ack_i,
   input wire [DATA_W-1:0] rd_data_i,
   output wire wr_valid_o,
   input wire wr_ready_i,
   output wire [7:0] wr_page_o,
   output wire [7:0] wr_addr_o,
   output wire [7:0] wr_data_o,
   input wire mdio_busy_i
);

   // =============================================
   // transaction states
   localparam [1:0] ST_CMD = 2'b00;
   localparam [1:0] ST_ADDR = 2'b01;
   localparam [1:0] ST_DATA = 2'b10;
   localparam [1:0] ST_IGNORE = 2'b11;

   // =============================================
   // pin synchronisers and edge detection
   wire [2:0] link_s;
   wire ss_n_s;
   wire sck_s;
   wire mosi_s;
   reg sck_d;
   reg ss_n_d;

   srac_sync #(
      .W(3),
      .RST(`SRAC_LINK_IDLE)
   ) u_sync (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .d_i({ss_n_i, sck_i, mosi_i}),
      .q_o(link_s)
   );

   assign ss_n_s = link_s[2];
   assign sck_s = link_s[1];
   assign mosi_s = link_s[0];

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sck_d <= 1'b1;
         ss_n_d <= 1'b1;
      end else begin
         sck_d <= sck_s;
         ss_n_d <= ss_n_s;
      end
   end

   wire sel = ~ss_n_s;
   wire start = ss_n_d & ~ss_n_s;
   wire sck_rise = sel & ~start & sck_s & ~sck_d; // RULE7 RULE24
   wire sck_fall = sel & ~start & ~sck_s & sck_d; // RULE24

   // =============================================
   // state
   reg [1:0] state;
   reg [2:0] bitcnt;
   reg [6:0] rx_sh;
   reg [7:0] tx_sh;
   reg [7:0] cmd;
   reg [7:0] addr;
   reg [IDX_W-1:0] idx;
   reg [7:0] page;
   reg [DATA_W-1:0] dport;
   reg ready;
   reg fast_stream;
   // ready bit as last shifted out: the stream must follow the byte the host saw
   reg fast_rdy_sent;
   reg wr_pend;
   reg [23:0] wr_word;
   reg trig;
   reg [7:0] trig_addr;

   wire byte_done = sck_rise & (bitcnt == `SRAC_BITS_PER_BYTE);
   wire [7:0] rx_byte = {rx_sh, mosi_s};
   wire buf_ready;
   wire is_write = cmd[`SRAC_CMD_RW]; // RULE8
   wire is_fast = cmd[`SRAC_CMD_MODE];
   wire [IDX_W-1:0] fast_off = cmd[`SRAC_CMD_TOP_HI:`SRAC_CMD_TOP_LO];
   wire busy = rd_req_o | wr_pend | wr_valid_o;

   // status: busy shows as done flag high, host waits for it to fall
   wire [7:0] status_byte = {busy, 1'b0, ready, 2'b00, mdio_busy_i, 2'b00}; // RULE15 RULE12
   wire [7:0] fast_status = {7'h00, ready};

   // =============================================
   // command checking
   wire cmd_tgt_ok = (rx_byte[`SRAC_CMD_TGT_HI:`SRAC_CMD_TGT_LO] == `SRAC_TARGET_ID); // RULE6
   wire cmd_norm_ok = rx_byte[`SRAC_CMD_MODE] |
      (rx_byte[`SRAC_CMD_TOP_HI:`SRAC_CMD_TOP_LO] == `SRAC_NORMAL_PATTERN); // RULE4
   wire cmd_no_fw = ~(rx_byte[`SRAC_CMD_MODE] & rx_byte[`SRAC_CMD_RW]); // RULE16
   wire cmd_ok = cmd_tgt_ok & cmd_norm_ok & cmd_no_fw;

   // =============================================
   // next byte to send for reads
   reg [7:0] next_tx;
   reg next_stream;
   reg [IDX_W-1:0] nidx;
   always @* begin
      next_tx = `SRAC_BYTE_ZERO;
      next_stream = fast_stream;
      nidx = idx;
      if (state == ST_ADDR) begin
         nidx = {IDX_W{1'b0}};
         if (is_fast) begin
            // fast read: status bytes until the data is in; the live flag
            // still belongs to the previous read, so the first byte says not ready
            next_tx = `SRAC_BYTE_ZERO; // RULE5 RULE21
            next_stream = 1'b0;
         end else begin
            case (rx_byte)
               `SRAC_ADDR_STATUS: next_tx = status_byte; // RULE15
               `SRAC_ADDR_PAGE: next_tx = page;
               `SRAC_ADDR_DATA: next_tx = dport[{nidx, 3'b000} +: 8]; // RULE22
               default: next_tx = `SRAC_BYTE_ZERO; // RULE20
            endcase
         end
      end else if (state == ST_DATA) begin
         if (is_fast) begin
            if (fast_stream) begin
               nidx = idx + 1'b1;
               next_tx = dport[{fast_off + nidx, 3'b000} +: 8]; // RULE5 RULE22
            end else if (fast_rdy_sent) begin
               // data only after a byte that carried the ready bit
               nidx = {IDX_W{1'b0}};
               next_stream = 1'b1;
               next_tx = dport[{fast_off, 3'b000} +: 8]; // RULE5
            end else begin
               next_tx = fast_status;
            end
         end else begin
            nidx = idx + 1'b1; // RULE9
            case (addr)
               `SRAC_ADDR_STATUS: next_tx = status_byte;
               `SRAC_ADDR_PAGE: next_tx = page;
               `SRAC_ADDR_DATA: next_tx = dport[{nidx, 3'b000} +: 8]; // RULE22
               default: next_tx = `SRAC_BYTE_ZERO;
            endcase
         end
      end
   end

   // =============================================
   // serial engine and byte protocol
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= ST_CMD;
         bitcnt <= 3'h0;
         rx_sh <= 7'h00;
         tx_sh <= `SRAC_BYTE_ZERO;
         cmd <= `SRAC_BYTE_ZERO;
         addr <= `SRAC_BYTE_ZERO;
         idx <= {IDX_W{1'b0}};
         fast_stream <= 1'b0;
         fast_rdy_sent <= 1'b0;
         miso_o <= 1'b0;
         miso_oe_o <= 1'b0;
         trig <= 1'b0;
         trig_addr <= `SRAC_BYTE_ZERO;
      end else begin
         trig <= 1'b0;
         miso_oe_o <= sel & ~start & (state != ST_IGNORE); // RULE27 RULE7
         if (start || !sel) begin
            // a new select always restarts at the command byte
            state <= ST_CMD; // RULE2 RULE11
            bitcnt <= 3'h0;
            tx_sh <= `SRAC_BYTE_ZERO;
            fast_stream <= 1'b0;
            fast_rdy_sent <= 1'b0;
         end else begin
            if (sck_fall) begin
               miso_o <= tx_sh[7]; // RULE1 RULE24
               tx_sh <= {tx_sh[6:0], 1'b0};
            end
            if (sck_rise) begin
               rx_sh <= rx_byte[6:0];
               bitcnt <= bitcnt + 3'h1;
            end
            if (byte_done) begin
               case (state)
                  ST_CMD: begin
                     cmd <= rx_byte;
                     state <= cmd_ok ? ST_ADDR : ST_IGNORE; // RULE2 RULE27
                  end
                  ST_ADDR: begin
                     addr <= rx_byte;
                     idx <= nidx;
                     state <= ST_DATA;
                     fast_stream <= next_stream;
                     fast_rdy_sent <= 1'b0;
                     if (!is_write) begin
                        tx_sh <= next_tx; // RULE1
                        // a read of a switch register loads the data register
                        if (is_fast || (rx_byte != `SRAC_ADDR_STATUS && rx_byte != `SRAC_ADDR_PAGE &&
                              rx_byte != `SRAC_ADDR_DATA)) begin
                           trig <= 1'b1; // RULE20
                           trig_addr <= rx_byte;
                        end
                     end
                  end
                  ST_DATA: begin
                     if (is_write) begin
                        idx <= idx + 1'b1; // RULE9
                     end else begin
                        tx_sh <= next_tx;
                        idx <= nidx;
                        fast_stream <= next_stream;
                        fast_rdy_sent <= next_tx[`SRAC_FAST_READY]; // RULE21
                     end
                  end
                  default: state <= ST_IGNORE; // RULE27
               endcase
            end
         end
      end
   end

   // =============================================
   // page and data transfer registers
   wire wr_byte = byte_done & sel & (state == ST_DATA) & is_write;
   wire [7:0] wr_at = addr + {{(8 - IDX_W){1'b0}}, idx}; // RULE9

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         page <= `SRAC_PAGE_RST;
         dport <= {DATA_W{1'b0}};
      end else begin
         if (wr_byte && addr == `SRAC_ADDR_PAGE) begin
            page <= rx_byte; // RULE13
         end
         if (rd_req_o && rd_ack_i) begin
            dport <= rd_data_i; // RULE14 RULE20
         end else if (wr_byte && addr == `SRAC_ADDR_DATA) begin
            dport[{idx, 3'b000} +: 8] <= rx_byte; // RULE14
         end
      end
   end

   // =============================================
   // internal read request and ready flag
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_req_o <= 1'b0;
         rd_page_o <= `SRAC_PAGE_RST;
         rd_addr_o <= `SRAC_BYTE_ZERO;
         ready <= 1'b0;
      end else begin
         if (trig) begin
            rd_req_o <= 1'b1;
            rd_page_o <= page; // RULE13
            rd_addr_o <= trig_addr;
         end else if (rd_ack_i) begin
            rd_req_o <= 1'b0;
         end
         // the arrival of data wins over a fresh request clearing it
         if (rd_req_o && rd_ack_i) begin
            ready <= 1'b1; // RULE21
         end else if (trig) begin
            ready <= 1'b0; // RULE21
         end
      end
   end

   // =============================================
   // write path into the two-entry buffer
   // the host cannot be stalled: a byte that finds the pending
   // slot still full replaces it, so the host must poll the done flag
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_pend <= 1'b0;
         wr_word <= 24'h000000;
      end else begin
         if (wr_byte && addr != `SRAC_ADDR_PAGE && addr != `SRAC_ADDR_DATA &&
               addr != `SRAC_ADDR_STATUS) begin
            wr_pend <= 1'b1; // RULE16
            wr_word <= {page, wr_at, rx_byte};
         end else if (buf_ready) begin
            wr_pend <= 1'b0;
         end
      end
   end

   srac_buf2 #(
      .W(24)
   ) u_buf (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(wr_pend),
      .in_ready_o(buf_ready),
      .in_data_i(wr_word),
      .out_valid_o(wr_valid_o),
      .out_ready_i(wr_ready_i),
      .out_data_o({wr_page_o, wr_addr_o, wr_data_o})
   );

endmodule // srac_top

//--- srac_top_sva.sv
`timescale 1ns/1ps
// =============================================
// port checker
module srac_top_sva (
   input wire clk_i,
   input wire arst_n_i,
   input wire ss_n_i,
   input wire sck_i,
   input wire miso_o,
   input wire miso_oe_o,
   input wire rd_req_o,
   input wire [7:0] rd_page_o,
   input wire [7:0] rd_addr_o,
   input wire rd_ack_i,
   input wire wr_valid_o,
   input wire wr_ready_i,
   input wire [7:0] wr_page_o,
   input wire [7:0] wr_addr_o,
   input wire [7:0] wr_data_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_oe_idle; ss_n_i [*5] |-> !miso_oe_o; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
   property p_oe_on; $fell(ss_n_i) |-> ##[2:6] miso_oe_o; endproperty
   a_oe_on: assert property (p_oe_on) else $error("miso not driven after select");
   // sync delay is 3-4 clk, so six quiet cycles leave no pending update
   property p_miso_hold; (sck_i && !ss_n_i && miso_oe_o) [*6] |-> $stable(miso_o); endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("miso moved with clock high");
   property p_req_hold; rd_req_o && !rd_ack_i |=> rd_req_o; endproperty
   a_req_hold: assert property (p_req_hold) else $error("read request dropped early");
   property p_req_drop; rd_req_o && rd_ack_i |=> !rd_req_o; endproperty
   a_req_drop: assert property (p_req_drop) else $error("read request kept after ack");
   property p_req_stable; rd_req_o && !rd_ack_i |=> $stable(rd_addr_o) && $stable(rd_page_o); endproperty
   a_req_stable: assert property (p_req_stable) else $error("read target moved");
   property p_wr_hold;
      wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable({wr_page_o, wr_addr_o, wr_data_o});
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("stalled write changed");
   property p_wr_sel; $rose(wr_valid_o) |-> $past(!ss_n_i); endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("write outside select");
   c_read: cover property (rd_req_o && rd_ack_i);
   c_write: cover property (wr_valid_o && !wr_ready_i);
   c_refuse: cover property ($fell(miso_oe_o) && !ss_n_i);
endmodule // srac_top_sva
bind srac_top srac_top_sva srac_top_sva_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .ss_n_i(ss_n_i), .sck_i(sck_i),
   .miso_o(miso_o), .miso_oe_o(miso_oe_o), .rd_req_o(rd_req_o), .rd_page_o(rd_page_o), .rd_addr_o(rd_addr_o),
   .rd_ack_i(rd_ack_i), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_page_o(wr_page_o),
   .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));

//--- srac_host.sv
`timescale 1ns/1ps
// =============================================
// serial master model, clock idles high, 160 ns bit
module srac_host (
   input wire clk_i,
   input wire miso_o,
   input wire miso_oe_o,
   output reg ss_n_o,
   output reg sck_o,
   output reg mosi_o
);
   reg oe_seen;
   // undriven line shows the inverse, so a missing enable cannot pass
   wire miso_pin = miso_oe_o ? miso_o : ~miso_o;
   initial begin
      ss_n_o = 1'b1;
      sck_o = 1'b1;
      mosi_o = 1'b1;
      oe_seen = 1'b0;
   end
   task automatic half;
      repeat (8) @(posedge clk_i);
   endtask
   task automatic xact(input [7:0] cmd, input [7:0] addr, input integer n, input [63:0] wd, output [63:0] rd);
      reg [15:0] hdr;
      integer i;
      begin
         hdr = {cmd, addr};
         rd = 64'h0;
         oe_seen = 1'b0;
         ss_n_o <= 1'b0;
         half;
         for (i = 0; i < 16 + 8 * n; i = i + 1) begin
            sck_o <= 1'b0;
            mosi_o <= (i < 16) ? hdr[15 - i] : wd[8 * (i / 8 - 2) + 7 - i % 8];
            half;
            sck_o <= 1'b1;
            if (i >= 16) begin
               rd[8 * (i / 8 - 2) + 7 - i % 8] = miso_pin;
               oe_seen = oe_seen | miso_oe_o;
            end
            half;
         end
         ss_n_o <= 1'b1;
         mosi_o <= ~mosi_o;
         repeat (24) @(posedge clk_i);
      end
   endtask
endmodule // srac_host

//--- srac_top_test.sv
`timescale 1ns/1ps
module srac_top_test;
   reg clk_i, arst_n_i, rd_ack_i, wr_ready_i, mdio_busy_i;
   reg [63:0] rd_data_i, rv;
   wire ss_n, sck, mosi, miso, miso_oe, rd_req, wr_valid;
   wire [7:0] rd_page, rd_addr, wr_page, wr_addr, wr_data;
   integer error_cnt, tests_run, cyc, dly, cnt, wn, k, j;
   reg [7:0] seen_page, seen_addr;
   reg [23:0] wq [0:7];
   srac_top srac_top_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .ss_n_i(ss_n), .sck_i(sck), .mosi_i(mosi),
      .miso_o(miso), .miso_oe_o(miso_oe), .rd_req_o(rd_req), .rd_page_o(rd_page), .rd_addr_o(rd_addr),
      .rd_ack_i(rd_ack_i), .rd_data_i(rd_data_i), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready_i),
      .wr_page_o(wr_page), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .mdio_busy_i(mdio_busy_i));
   srac_host srac_host_inst (.clk_i(clk_i), .miso_o(miso), .miso_oe_o(miso_oe), .ss_n_o(ss_n), .sck_o(sck),
      .mosi_o(mosi));
   function [63:0] regval(input [7:0] a);
      regval = 64'h8877665544332211 ^ {8{a}};
   endfunction
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // =============================================
   // register source, slow or prompt; data toggles when not acked
   always @(posedge clk_i) begin
      rd_ack_i <= 1'b0;
      rd_data_i <= ~rd_data_i;
      if (!rd_req) cnt <= 0;
      else if (!rd_ack_i) begin
         cnt <= cnt + 1;
         if (cnt == dly) begin
            rd_ack_i <= 1'b1;
            rd_data_i <= regval(rd_addr);
            seen_page <= rd_page;
            seen_addr <= rd_addr;
         end
      end
      if (wr_valid && wr_ready_i) begin
         wq[wn % 8] <= {wr_page, wr_addr, wr_data};
         wn <= wn + 1;
      end
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt = error_cnt + 1;
         stop_test;
      end
   end
   task automatic check(input string name, input [63:0] exp, input [63:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
         end
      end
   endtask
   task automatic x(input [7:0] c, input [7:0] a, input integer n, input [63:0] w);
      srac_host_inst.xact(c, a, n, w, rv);
   endtask
   task automatic t_status;
      begin
         x(8'h60, 8'hFF, 1, 0);
         check("page reset", 8'h00, rv[7:0]);
         mdio_busy_i <= 1'b1;
         x(8'h60, 8'hFE, 1, 0);
         check("status mdio", 8'h04, rv[7:0]);
         mdio_busy_i <= 1'b0;
         x(8'h60, 8'hFE, 1, 0);
         check("status idle", 8'h00, rv[7:0]);
         $display("test status done");
      end
   endtask
   task automatic t_normal_read;
      begin
         dly = 1000;
         x(8'h61, 8'hFF, 1, 64'h10);
         x(8'h60, 8'hFF, 1, 0);
         check("page", 8'h10, rv[7:0]);
         x(8'h60, 8'h12, 1, 0);
         x(8'h60, 8'hFE, 1, 0);
         check("status pending", 8'h80, rv[7:0]);
         k = 0;
         while (k < 8 && rv[5] !== 1'b1) begin
            x(8'h60, 8'hFE, 1, 0);
            k = k + 1;
         end
         check("status ready", 8'h20, rv[7:0]);
         check("read page", 8'h10, seen_page);
         check("read addr", 8'h12, seen_addr);
         x(8'h60, 8'hF0, 8, 0);
         check("data", regval(8'h12), rv);
         $display("test normal read done");
      end
   endtask
   task automatic t_fast_read;
      begin
         // fast access kept to this one test, never interleaved within it
         dly = 0;
         x(8'h50, 8'h34, 6, 0);
         k = 0;
         while (k < 2 && rv[8 * k +: 8] !== 8'h01) k = k + 1;
         check("fast ready", 8'h01, rv[8 * k +: 8]);
         for (j = 1; j < 4; j = j + 1) begin
            check("fast data", regval(8'h34) >> (8 * (j + 1)) & 64'hFF, rv[8 * (k + j) +: 8]);
         end
         // page write skipped: still the page of the previous read
         check("fast page", 8'h10, seen_page);
         check("fast addr", 8'h34, seen_addr);
         $display("test fast read done");
      end
   endtask
   task automatic t_write;
      begin
         wr_ready_i <= 1'b0;
         wn = 0;
         x(8'h61, 8'h20, 2, 64'hBBAA);
         x(8'h60, 8'hFE, 1, 0);
         check("busy", 1, rv[7]);
         wr_ready_i <= 1'b1;
         repeat (8) @(posedge clk_i);
         check("writes", 2, wn);
         check("write 0", 24'h1020AA, wq[0]);
         check("write 1", 24'h1021BB, wq[1]);
         x(8'h60, 8'hFE, 1, 0);
         check("done", 0, rv[7]);
         x(8'h61, 8'hF0, 2, 64'h5AA5);
         x(8'h60, 8'hF0, 2, 0);
         check("data reg", 16'h5AA5, rv[15:0]);
         $display("test write done");
      end
   endtask
   task automatic t_refuse;
      reg [7:0] bad [0:3];
      begin
         bad[0] = 8'h62;
         bad[1] = 8'h63;
         bad[2] = 8'h41;
         bad[3] = 8'h11;
         wn = 0;
         for (j = 0; j < 4; j = j + 1) begin
            x(bad[j], 8'h20, 1, 64'h77);
            check("refused oe", 0, srac_host_inst.oe_seen);
         end
         repeat (8) @(posedge clk_i);
         check("refused writes", 0, wn);
         $display("test refuse done");
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d, mismatches %0d", tests_run, error_cnt);
         if (error_cnt == 0 && tests_run > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      arst_n_i = 1'b0;
      rd_ack_i = 1'b0;
      wr_ready_i = 1'b1;
      mdio_busy_i = 1'b0;
      rd_data_i = 64'h0;
      error_cnt = 0;
      tests_run = 0;
      cyc = 0;
      cnt = 0;
      wn = 0;
      dly = 0;
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      t_status;
      t_normal_read;
      t_fast_read;
      t_write;
      t_refuse;
      stop_test;
   end
endmodule // srac_top_test
